// ### hdl/sdc_checker.sv
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - User descriptor: type bit 11 clear is data, set is code.
// - Expand-down (bit 10): limit is lower bound, bit 22 picks upper bound.
// - Expand-down accepts offsets limit+1 to upper bound, rejects others.
// - Expand-up accepts offsets zero through the limit inclusive.
// - Bit 9 writable; a write to a read-only data segment faults.
// - Loading a data/stack register sets accessed bit 8; only a host write to the upper word clears it.
// - Expand-down upper bound: 32-bit max if bit 22 set, else 16-bit.
// - Stack loads: bit 22 selects 32-bit or 16-bit stack pointer.
// - Stack load needs a writable data descriptor, else rejected.
// - Data types 0..7 decode expand-down, writable, accessed bits.
// - System flag clear means system descriptor, kind from type.
// - System types 0000, 1000, 1010, 1101 are illegal.
// - Decode local table, available and busy task-state kinds.
// - Decode call, task, interrupt and trap gate kinds.
// - Interrupt/trap gates only from interrupt table; call gates not.
// - System flag is upper bit 12, type is upper bits 11..8.
// - Granularity set scales the limit by 4096-byte blocks.
// - Absent descriptor raises absent fault; present bit untouched.
module sdc_checker
  import sdc_pkg::*;
(
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Check results
  output logic gp_fault_o,
  output logic absent_fault_o,
  output logic check_done_o
);
  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  function automatic logic sys_illegal(input logic [3:0] t);
    return (t == SDC_T_RSV0) || (t == SDC_T_RSV8) ||
           (t == SDC_T_RSVA) || (t == SDC_T_RSVD);
  endfunction

  function automatic logic [3:0] kind_of(input logic [31:0] hi);
    logic [3:0] t;
    t = hi[SDC_TYPE_LSB +: 4];
    if (hi[SDC_BIT_SYS]) begin
      return hi[SDC_BIT_CODE] ? SDC_K_CODE : SDC_K_DATA;
    end
    case (t)
      SDC_T_LDT: return SDC_K_LDT;
      SDC_T_TSS16A, SDC_T_TSS32A: return SDC_K_TSS_AVL;
      SDC_T_TSS16B, SDC_T_TSS32B: return SDC_K_TSS_BUSY;
      SDC_T_CALL16, SDC_T_CALL32: return SDC_K_CALL;
      SDC_T_TASKG: return SDC_K_TASK;
      SDC_T_INT16, SDC_T_INT32: return SDC_K_INTR;
      SDC_T_TRAP16, SDC_T_TRAP32: return SDC_K_TRAP;
      default: return SDC_K_ILLEGAL;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [31:0] ctrl_q, ctrl_d, lo_q, lo_d, hi_q, hi_d, off_q, off_d;
  logic [31:0] res_q, res_d, gate_q, gate_d;
  logic gp_q, gp_d, np_q, np_d, done_q, done_d;
  logic aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [7:0] aw_q, aw_d;
  logic [31:0] wd_q, wd_d;
  logic [3:0] ws_q, ws_d;
  logic bv_q, bv_d, rv_q, rv_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  logic [31:0] rd_q, rd_d;
  logic awrdy_q, awrdy_d, wrdy_q, wrdy_d, arrdy_q, arrdy_d;

  // ------------------------------------------------------------
  // Check datapath
  // ------------------------------------------------------------
  logic [3:0] kind;
  logic [19:0] raw_lim;
  logic [31:0] lim, upper;
  logic in_range, wr_ok, is_data, fault_gp, fault_np, go;
  logic [1:0] tbl;
  logic gate_bad;

  always_comb begin
    kind = kind_of(hi_q);
    tbl = ctrl_q[SDC_CTL_TBL_LSB +: 2];
    raw_lim = {hi_q[SDC_LIMHI_LSB +: 4], lo_q[15:0]};
    lim = hi_q[SDC_BIT_GRAN] ? {raw_lim, SDC_GRAN_FILL}
                             : {12'h000, raw_lim};
    upper = hi_q[SDC_BIT_DSIZE] ? SDC_MAX_32 : SDC_MAX_16;
    is_data = (kind == SDC_K_DATA);
    if (hi_q[SDC_BIT_EXPD]) begin
      in_range = (off_q > lim) && (off_q <= upper);
    end else begin
      in_range = (off_q <= lim);
    end
    wr_ok = hi_q[SDC_BIT_WR];
    gate_bad = 1'b0;
    if ((kind == SDC_K_INTR || kind == SDC_K_TRAP) && tbl != SDC_TBL_INTR)
      gate_bad = 1'b1;
    if (kind == SDC_K_CALL && tbl == SDC_TBL_INTR)
      gate_bad = 1'b1;
    fault_np = !hi_q[SDC_BIT_PRES];
    fault_gp = 1'b0;
    if (kind == SDC_K_ILLEGAL) fault_gp = 1'b1;
    if (gate_bad) fault_gp = 1'b1;
    if (is_data && !in_range) fault_gp = 1'b1;
    if (is_data && ctrl_q[SDC_CTL_WRITE] && !wr_ok) fault_gp = 1'b1;
    if (ctrl_q[SDC_CTL_STACK] && !(is_data && wr_ok))
      fault_gp = 1'b1;
    if (kind == SDC_K_CALL && hi_q[SDC_BIT_SYS]) fault_gp = 1'b1;
  end

  // ------------------------------------------------------------
  // AXI4-Lite slave and check sequencing
  // ------------------------------------------------------------
  logic do_wr, do_rd;
  always_comb begin
    ctrl_d = ctrl_q; lo_d = lo_q; hi_d = hi_q; off_d = off_q;
    res_d = res_q; gate_d = gate_q; gp_d = gp_q; np_d = np_q;
    done_d = 1'b0;
    aw_got_d = aw_got_q; w_got_d = w_got_q; aw_d = aw_q;
    wd_d = wd_q; ws_d = ws_q; bv_d = bv_q; br_d = br_q;
    rv_d = rv_q; rr_d = rr_q; rd_d = rd_q;
    go = 1'b0;
    if (s_axi_awvalid_i && !aw_got_q && !bv_q) begin
      aw_got_d = 1'b1;
      aw_d = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !w_got_q && !bv_q) begin
      w_got_d = 1'b1;
      wd_d = s_axi_wdata_i;
      ws_d = s_axi_wstrb_i;
    end
    do_wr = aw_got_q && w_got_q && !bv_q;
    if (do_wr) begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bv_d = 1'b1;
      br_d = SDC_RESP_OKAY;
      case (aw_q)
        SDC_OFF_CTRL: begin
          ctrl_d = wd_q;
          go = wd_q[SDC_CTL_GO] && ws_q[0];
          ctrl_d[SDC_CTL_GO] = go;
        end
        SDC_OFF_DESC_LO: lo_d = wd_q;
        SDC_OFF_DESC_HI: hi_d = wd_q;
        SDC_OFF_OFFSET: off_d = wd_q;
        default: br_d = SDC_RESP_SLVERR;
      endcase
    end
    if (bv_q && s_axi_bready_i) bv_d = 1'b0;
    if (ctrl_q[SDC_CTL_GO]) begin
      // A go written in this very cycle survives the self-clear
      ctrl_d[SDC_CTL_GO] = go;
      done_d = 1'b1;
      gp_d = fault_gp;
      np_d = fault_np;
      res_d = {20'h00000, hi_q[SDC_BIT_DSIZE], in_range, wr_ok,
               hi_q[SDC_BIT_EXPD], hi_q[SDC_BIT_SYS], 3'h0, kind};
      gate_d = {lo_q[31:16], lo_q[15:0]};
      if (ctrl_q[SDC_CTL_LOAD] && is_data && !fault_gp && !fault_np)
        hi_d[SDC_BIT_ACC] = 1'b1;
    end
    do_rd = s_axi_arvalid_i && !rv_q;
    if (do_rd) begin
      rv_d = 1'b1;
      rr_d = SDC_RESP_OKAY;
      case (s_axi_araddr_i)
        SDC_OFF_CTRL: rd_d = ctrl_q;
        SDC_OFF_DESC_LO: rd_d = lo_q;
        SDC_OFF_DESC_HI: rd_d = hi_q;
        SDC_OFF_OFFSET: rd_d = off_q;
        SDC_OFF_STATUS: rd_d = {29'h0, done_q, np_q, gp_q};
        SDC_OFF_RESULT: rd_d = res_q;
        SDC_OFF_GATE: rd_d = gate_q;
        default: begin
          rd_d = 32'h0;
          rr_d = SDC_RESP_SLVERR;
        end
      endcase
    end else if (rv_q && s_axi_rready_i) begin
      rv_d = 1'b0;
    end
    // Readys leave from flops, one step ahead of the hold conditions
    awrdy_d = !aw_got_d && !bv_d;
    wrdy_d = !w_got_d && !bv_d;
    arrdy_d = !rv_d;
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= 32'h0; lo_q <= 32'h0; hi_q <= 32'h0; off_q <= 32'h0;
      res_q <= 32'h0; gate_q <= 32'h0;
      gp_q <= 1'b0; np_q <= 1'b0; done_q <= 1'b0;
      aw_got_q <= 1'b0; w_got_q <= 1'b0; aw_q <= 8'h00;
      wd_q <= 32'h0; ws_q <= 4'h0;
      bv_q <= 1'b0; br_q <= 2'h0; rv_q <= 1'b0; rr_q <= 2'h0;
      rd_q <= 32'h0;
      awrdy_q <= 1'b1;
      wrdy_q <= 1'b1;
      arrdy_q <= 1'b1;
    end else if (clk_en_i) begin
      ctrl_q <= ctrl_d; lo_q <= lo_d; hi_q <= hi_d; off_q <= off_d;
      res_q <= res_d; gate_q <= gate_d;
      gp_q <= gp_d; np_q <= np_d; done_q <= done_d;
      aw_got_q <= aw_got_d; w_got_q <= w_got_d; aw_q <= aw_d;
      wd_q <= wd_d; ws_q <= ws_d;
      bv_q <= bv_d; br_q <= br_d; rv_q <= rv_d; rr_q <= rr_d;
      rd_q <= rd_d;
      awrdy_q <= awrdy_d;
      wrdy_q <= wrdy_d;
      arrdy_q <= arrdy_d;
    end
  end

  assign s_axi_awready_o = awrdy_q;
  assign s_axi_wready_o = wrdy_q;
  assign s_axi_bvalid_o = bv_q;
  assign s_axi_bresp_o = br_q;
  assign s_axi_arready_o = arrdy_q;
  assign s_axi_rvalid_o = rv_q;
  assign s_axi_rresp_o = rr_q;
  assign s_axi_rdata_o = rd_q;
  assign gp_fault_o = gp_q;
  assign absent_fault_o = np_q;
  assign check_done_o = done_q;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_check_run;
    clk_en_i && ctrl_q[SDC_CTL_GO];
  endsequence

  property p_done;
    @(posedge core_clk_i) disable iff (!resetn_i)
      s_check_run |=> check_done_o;
  endproperty
  a_done: assert property (p_done) else $error("done missing");

  property p_absent;
    @(posedge core_clk_i) disable iff (!resetn_i)
      s_check_run ##0 !hi_q[SDC_BIT_PRES] |=> absent_fault_o;
  endproperty
  a_absent: assert property (p_absent) else $error("absent fault");

  property p_present_kept;
    @(posedge core_clk_i) disable iff (!resetn_i)
      clk_en_i && !do_wr |=> $stable(hi_q[SDC_BIT_PRES]);
  endproperty
  a_present_kept: assert property (p_present_kept)
    else $error("present bit changed");

  property p_illegal;
    @(posedge core_clk_i) disable iff (!resetn_i)
      s_check_run ##0 !hi_q[SDC_BIT_SYS] &&
      sys_illegal(hi_q[SDC_TYPE_LSB +: 4]) |=> gp_fault_o;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal type");

  property p_ro_write;
    @(posedge core_clk_i) disable iff (!resetn_i)
      s_check_run ##0 is_data && ctrl_q[SDC_CTL_WRITE] && !hi_q[SDC_BIT_WR]
      |=> gp_fault_o;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("ro write");

  property p_stack;
    @(posedge core_clk_i) disable iff (!resetn_i)
      s_check_run ##0 ctrl_q[SDC_CTL_STACK] && !hi_q[SDC_BIT_WR]
      |=> gp_fault_o;
  endproperty
  a_stack: assert property (p_stack) else $error("stack load");

  property p_expup;
    @(posedge core_clk_i) disable iff (!resetn_i)
      s_check_run ##0 is_data && !hi_q[SDC_BIT_EXPD] && off_q > lim
      |=> gp_fault_o;
  endproperty
  a_expup: assert property (p_expup) else $error("expand-up range");

  property p_expdn;
    @(posedge core_clk_i) disable iff (!resetn_i)
      s_check_run ##0 is_data && hi_q[SDC_BIT_EXPD] && off_q <= lim
      |=> gp_fault_o;
  endproperty
  a_expdn: assert property (p_expdn) else $error("expand-down range");

  property p_accessed;
    @(posedge core_clk_i) disable iff (!resetn_i)
      s_check_run ##0 ctrl_q[SDC_CTL_LOAD] && is_data && !fault_gp &&
      !fault_np |=> hi_q[SDC_BIT_ACC];
  endproperty
  a_accessed: assert property (p_accessed) else $error("accessed");

  property p_intr_tbl;
    @(posedge core_clk_i) disable iff (!resetn_i)
      s_check_run ##0 kind == SDC_K_INTR && tbl != SDC_TBL_INTR
      |=> gp_fault_o;
  endproperty
  a_intr_tbl: assert property (p_intr_tbl) else $error("gate table");

  property p_trap_tbl;
    @(posedge core_clk_i) disable iff (!resetn_i)
      s_check_run ##0 kind == SDC_K_TRAP && tbl != SDC_TBL_INTR
      |=> gp_fault_o;
  endproperty
  a_trap_tbl: assert property (p_trap_tbl) else $error("trap table");

  property p_call_tbl;
    @(posedge core_clk_i) disable iff (!resetn_i)
      s_check_run ##0 kind == SDC_K_CALL && tbl == SDC_TBL_INTR
      |=> gp_fault_o;
  endproperty
  a_call_tbl: assert property (p_call_tbl) else $error("call table");

  property p_acc_kept;
    @(posedge core_clk_i) disable iff (!resetn_i)
      clk_en_i && !do_wr && hi_q[SDC_BIT_ACC] |=> hi_q[SDC_BIT_ACC];
  endproperty
  a_acc_kept: assert property (p_acc_kept) else $error("accessed lost");

  property p_gate_word;
    @(posedge core_clk_i) disable iff (!resetn_i)
      s_check_run |=> gate_q == $past(lo_q);
  endproperty
  a_gate_word: assert property (p_gate_word) else $error("gate word");
endmodule // sdc_checker

// ### hdl/sdc_pkg.sv
package sdc_pkg;
  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] SDC_OFF_CTRL = 8'h00;
  localparam logic [7:0] SDC_OFF_DESC_LO = 8'h04;
  localparam logic [7:0] SDC_OFF_DESC_HI = 8'h08;
  localparam logic [7:0] SDC_OFF_OFFSET = 8'h0C;
  localparam logic [7:0] SDC_OFF_STATUS = 8'h10;
  localparam logic [7:0] SDC_OFF_RESULT = 8'h14;
  localparam logic [7:0] SDC_OFF_GATE = 8'h18;
  // ------------------------------------------------------------
  // Upper descriptor word fields
  // ------------------------------------------------------------
  localparam int SDC_BIT_ACC = 8;
  localparam int SDC_BIT_WR = 9;
  localparam int SDC_BIT_EXPD = 10;
  localparam int SDC_BIT_CODE = 11;
  localparam int SDC_BIT_SYS = 12;
  localparam int SDC_BIT_PRES = 15;
  localparam int SDC_BIT_DSIZE = 22;
  localparam int SDC_BIT_GRAN = 23;
  localparam int SDC_TYPE_LSB = 8;
  localparam int SDC_LIMHI_LSB = 16;
  localparam int SDC_GRAN_SHIFT = 12;
  localparam logic [31:0] SDC_MAX_32 = 32'hFFFFFFFF;
  localparam logic [31:0] SDC_MAX_16 = 32'h0000FFFF;
  localparam logic [11:0] SDC_GRAN_FILL = 12'hFFF;
  // ------------------------------------------------------------
  // Control word fields
  // ------------------------------------------------------------
  localparam int SDC_CTL_GO = 0;
  localparam int SDC_CTL_WRITE = 1;
  localparam int SDC_CTL_LOAD = 2;
  localparam int SDC_CTL_STACK = 3;
  localparam int SDC_CTL_TBL_LSB = 4;
  // Table a descriptor came from
  localparam logic [1:0] SDC_TBL_GLOBAL = 2'h0;
  localparam logic [1:0] SDC_TBL_LOCAL = 2'h1;
  localparam logic [1:0] SDC_TBL_INTR = 2'h2;
  // ------------------------------------------------------------
  // System type codes
  // ------------------------------------------------------------
  localparam logic [3:0] SDC_T_RSV0 = 4'h0;
  localparam logic [3:0] SDC_T_TSS16A = 4'h1;
  localparam logic [3:0] SDC_T_LDT = 4'h2;
  localparam logic [3:0] SDC_T_TSS16B = 4'h3;
  localparam logic [3:0] SDC_T_CALL16 = 4'h4;
  localparam logic [3:0] SDC_T_TASKG = 4'h5;
  localparam logic [3:0] SDC_T_INT16 = 4'h6;
  localparam logic [3:0] SDC_T_TRAP16 = 4'h7;
  localparam logic [3:0] SDC_T_RSV8 = 4'h8;
  localparam logic [3:0] SDC_T_TSS32A = 4'h9;
  localparam logic [3:0] SDC_T_RSVA = 4'hA;
  localparam logic [3:0] SDC_T_TSS32B = 4'hB;
  localparam logic [3:0] SDC_T_CALL32 = 4'hC;
  localparam logic [3:0] SDC_T_RSVD = 4'hD;
  localparam logic [3:0] SDC_T_INT32 = 4'hE;
  localparam logic [3:0] SDC_T_TRAP32 = 4'hF;
  // Decoded kind, as reported in the result register
  localparam logic [3:0] SDC_K_DATA = 4'h0;
  localparam logic [3:0] SDC_K_CODE = 4'h1;
  localparam logic [3:0] SDC_K_ILLEGAL = 4'h2;
  localparam logic [3:0] SDC_K_LDT = 4'h3;
  localparam logic [3:0] SDC_K_TSS_AVL = 4'h4;
  localparam logic [3:0] SDC_K_TSS_BUSY = 4'h5;
  localparam logic [3:0] SDC_K_CALL = 4'h6;
  localparam logic [3:0] SDC_K_TASK = 4'h7;
  localparam logic [3:0] SDC_K_INTR = 4'h8;
  localparam logic [3:0] SDC_K_TRAP = 4'h9;
  // AXI responses
  localparam logic [1:0] SDC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SDC_RESP_SLVERR = 2'h2;
endpackage

// ### testbench/sdc_host.sv
`timescale 1ns/1ps
module sdc_host (
  // Clock
  input wire logic core_clk_i,
  // Write channels
  output logic [7:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic bvalid_i,
  output logic bready_o,
  // Read channels
  output logic [7:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic rvalid_i,
  output logic rready_o,
  // Raised when a response never came
  output logic hang_o
);
  initial begin
    awaddr_o = 8'h00;
    awvalid_o = 1'b0;
    wdata_o = 32'h0;
    wstrb_o = 4'hF;
    wvalid_o = 1'b0;
    bready_o = 1'b0;
    araddr_o = 8'h00;
    arvalid_o = 1'b0;
    rready_o = 1'b0;
    hang_o = 1'b0;
  end

  // Released lines flip so a stale value is never mistaken for a live one
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk_i);
    awaddr_o <= a;
    wdata_o <= d;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge core_clk_i);
      if (awvalid_o && awready_i) begin
        awvalid_o <= 1'b0;
        awaddr_o <= ~a;
      end
      if (wvalid_o && wready_i) begin
        wvalid_o <= 1'b0;
        wdata_o <= ~d;
      end
      if (bvalid_i && bready_o) break;
    end
    bready_o <= 1'b0;
    if (n == 200) hang_o <= 1'b1;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge core_clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge core_clk_i);
      if (arvalid_o && arready_i) begin
        arvalid_o <= 1'b0;
        araddr_o <= ~a;
      end
      if (rvalid_i && rready_o) break;
    end
    rready_o <= 1'b0;
    if (n == 200) hang_o <= 1'b1;
  endtask
endmodule // sdc_host

// ### testbench/sdc_checker_test.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR at %0t: got %h expected %h", $time, g, e); end end
module sdc_checker_test
  import sdc_pkg::*;
;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic [1:0] r;
  } sdc_exp_s;
  logic core_clk_i, resetn_i, awvalid, awready, wvalid, wready, bvalid;
  logic bready, arvalid, arready, rvalid, rready, gp, ab, done, hang;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, x, lo, hi, off, lim;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, eb, ef;
  logic [5:0] ctl;
  sdc_exp_s er;
  sdc_exp_s rq[$];
  logic [1:0] bq[$];
  logic [1:0] fq[$];
  int n_fail = 0;
  int checks_done = 0;
  int seed = 45;

  sdc_checker u_sdc_checker (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .clk_en_i(1'b1), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .gp_fault_o(gp), .absent_fault_o(ab), .check_done_o(done));
  sdc_host u_sdc_host (.core_clk_i(core_clk_i), .awaddr_o(awaddr),
    .awvalid_o(awvalid), .awready_i(awready), .wdata_o(wdata),
    .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready),
    .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
    .arvalid_o(arvalid), .arready_i(arready), .rvalid_i(rvalid),
    .rready_o(rready), .hang_o(hang));

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // -----------------------------------------------------------
  // Result watcher
  // -----------------------------------------------------------
  always @(posedge core_clk_i) begin
    if (rvalid && rready) begin
      er = rq.pop_front();
      `CHK({rresp, rdata & er.m}, {er.r, er.d})
    end
    if (bvalid && bready) begin
      eb = bq.pop_front();
      `CHK(bresp, eb)
    end
    if (done) begin
      ef = fq.pop_front();
      `CHK({gp, ab}, ef)
    end
  end

  always @(posedge hang) begin
    n_fail++;
    wrap_up();
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d,
                   input logic [1:0] rs);
    bq.push_back(rs);
    u_sdc_host.wr(a, d);
  endtask

  task automatic r(input logic [7:0] a, input logic [31:0] d, m,
                   input logic [1:0] rs);
    rq.push_back('{d & m, m, rs});
    u_sdc_host.rd(a);
  endtask

  function automatic logic [31:0] lim_of(input logic [31:0] l, h);
    lim_of = {12'h000, h[19:16], l[15:0]};
    if (h[23]) lim_of = {lim_of[19:0], SDC_GRAN_FILL};
  endfunction

  // Expected outcome of one check, worked out from the descriptor
  function automatic void predict(input logic [5:0] c,
    input logic [31:0] l, h, o, output logic g, output logic [31:0] rs, m);
    logic [3:0] t;
    logic [31:0] top;
    logic ok;
    t = h[11:8];
    top = h[22] ? SDC_MAX_32 : SDC_MAX_16;
    ok = h[10] ? (o > lim_of(l, h) && o <= top) : (o <= lim_of(l, h));
    g = 1'b0;
    m = 32'hF;
    rs = 32'h0;
    if (h[12] && !t[3]) begin
      m = 32'hF0F;
      rs[11:8] = {h[22], ok, t[1], t[2]};
      g = !ok | (c[1] & !t[1]) | (c[3] & !t[1]);
    end else if (h[12]) begin
      rs[3:0] = SDC_K_CODE;
      g = c[3];
    end else begin
      case (t)
        4'h0, 4'h8, 4'hA, 4'hD: begin
          rs[3:0] = SDC_K_ILLEGAL;
          g = 1'b1;
        end
        4'h2: rs[3:0] = SDC_K_LDT;
        4'h1, 4'h9: rs[3:0] = SDC_K_TSS_AVL;
        4'h3, 4'hB: rs[3:0] = SDC_K_TSS_BUSY;
        4'h5: rs[3:0] = SDC_K_TASK;
        4'h4, 4'hC: begin
          rs[3:0] = SDC_K_CALL;
          g = c[5:4] == SDC_TBL_INTR;
        end
        default: begin
          rs[3:0] = t[0] ? SDC_K_TRAP : SDC_K_INTR;
          g = c[5:4] != SDC_TBL_INTR;
        end
      endcase
    end
  endfunction

  task automatic run(input logic [5:0] c, input logic [31:0] l, h, o);
    logic g;
    logic [31:0] rs, m, hx;
    predict(c, l, h, o, g, rs, m);
    w(SDC_OFF_DESC_LO, l, SDC_RESP_OKAY);
    w(SDC_OFF_DESC_HI, h, SDC_RESP_OKAY);
    w(SDC_OFF_OFFSET, o, SDC_RESP_OKAY);
    fq.push_back({g, !h[15]});
    w(SDC_OFF_CTRL, {26'h0, c}, SDC_RESP_OKAY);
    repeat (2) @(posedge core_clk_i);
    r(SDC_OFF_RESULT, rs, m, SDC_RESP_OKAY);
    r(SDC_OFF_STATUS, {30'h0, !h[15], g}, 32'h3, SDC_RESP_OKAY);
    hx = h;
    if (rs[3:0] == SDC_K_DATA && h[12] && c[2] && !g && h[15]) hx[8] = 1'b1;
    r(SDC_OFF_DESC_HI, hx, SDC_MAX_32, SDC_RESP_OKAY);
    if (rs[3:0] == SDC_K_CALL && !h[12])
      r(SDC_OFF_GATE, l, SDC_MAX_32, SDC_RESP_OKAY);
  endtask

  initial begin
    resetn_i = 1'b0;
    repeat (5) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    // Unmapped word is refused on both paths
    w(8'h1C, 32'h5A5A5A5A, SDC_RESP_SLVERR);
    r(8'h1C, 32'h0, SDC_MAX_32, SDC_RESP_SLVERR);
    // Every system code, from every table
    for (int i = 0; i < 48; i++) begin
      x = $random(seed);
      hi = (x & 32'hFF0000FF) | 32'h8000 | ((i % 16) << 8);
      run({2'(i / 16), 1'b0, 2'(i % 2) << 1, 1'b1}, $random(seed), hi, x);
    end
    // Data and code segments around the range edges
    for (int i = 0; i < 60; i++) begin
      x = $random(seed);
      lo = $random(seed);
      hi = (x & 32'hFFCF0FFF) | 32'h9000;
      lim = lim_of(lo, hi);
      case (x[13:12])
        2'h0: off = lim;
        2'h1: off = lim + 32'h1;
        2'h2: off = SDC_MAX_16;
        default: off = SDC_MAX_16 + 32'h1;
      endcase
      ctl = {1'b0, x[14], x[15], x[15] | x[16], x[17] & !hi[11], 1'b1};
      run(ctl, lo, hi, off);
    end
    // Absent but otherwise legal writable data segment
    run(6'h05, 32'h0000FFFF, 32'h00001200, 32'h0);
    repeat (4) @(posedge core_clk_i);
    `CHK(rq.size() + bq.size() + fq.size(), 0)
    wrap_up();
  end
endmodule // sdc_checker_test
